// *** pam_regs.vh ***
/*
 * Register indices, field positions and fixed codes of the mailbox block.
 * Assumes inclusion by bare name from each design file that needs them.
 */
`ifndef PAM_REGS_VH
`define PAM_REGS_VH

// Register group on addr[3:2] and register index on addr[3:0], either port
`define PAM_GRP_H2L      2'h0
`define PAM_GRP_L2H      2'h1
`define PAM_A_FLAGS      4'h8
`define PAM_A_IRQ        4'h9
`define PAM_A_CTRL       4'ha

// Host interrupt control register fields
`define PAM_HI_IN_EN     12
`define PAM_HI_IN_SEL    11:8
`define PAM_HI_OUT_EN    4
`define PAM_HI_OUT_SEL   3:0
`define PAM_HI_OUT_IND   16
`define PAM_HI_IN_IND    17

// Local interrupt control register fields
`define PAM_LI_IN_EN     4
`define PAM_LI_IN_SEL    3:0
`define PAM_LI_OUT_EN    12
`define PAM_LI_OUT_SEL   11:8
`define PAM_LI_IN_IND    16
`define PAM_LI_OUT_IND   17

// Writable configuration bits and their reset value
`define PAM_CFG_MASK     16'h1f1f
`define PAM_CFG_RST      16'h0000

// Write-only global flag reset in both control registers
`define PAM_FLAG_RST_BIT 27

// Direct byte: mailbox 4 byte 3 selector and flag index
`define PAM_DIRECT_SEL   4'hf
`define PAM_DIRECT_FLAG  15

`endif

// *** pam_rise.v ***
/*
 * Rising-edge detector on a synchronous level input.
 * Assumes the input is already synchronous to clock.
 */
`timescale 1ns/100ps
`default_nettype none

module pam_rise #(
  parameter IDLE = 1'b1
) (
  // Clock, reset and enable
  input  wire clock,
  input  wire rst_b,
  input  wire ce,
  // Level in, pulse out
  input  wire d,
  output wire rise
);

  reg d_q;

  // Previous sample; idle level avoids a false edge after reset
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      d_q <= IDLE;
    end else if (ce) begin
      d_q <= d;
    end
  end

  assign rise = ce & d & ~d_q;

endmodule

`default_nettype wire

// *** pam_mailbox.v ***
/*
 * Bidirectional mailbox block: four words each way between a host
 * target port and a synchronous local bus, byte flags, global flag
 * reset, mailbox interrupts and a direct hardware byte path.
 * Assumes all inputs synchronous to clock; one access per strobe cycle.
 */
`timescale 1ns/100ps
`default_nettype none
`include "pam_regs.vh"

module pam_mailbox (
  // Clock, reset, enable
  input  wire        clock,
  input  wire        rst_b,
  input  wire        ce,
  // Boot strap
  input  wire        boot_bytewide,
  // Host target port
  input  wire        host_sel,
  input  wire        host_wr,
  input  wire        host_burst,
  input  wire [3:0]  host_addr,
  input  wire [3:0]  host_be,
  input  wire [31:0] host_wdata,
  output reg  [31:0] host_rdata_q,
  output wire        host_stop,
  output wire        host_inta_b,
  // Local bus port
  input  wire        local_sel,
  input  wire        local_wr_b,
  input  wire        local_rd_b,
  input  wire [3:0]  local_addr,
  input  wire [3:0]  local_be,
  input  wire [31:0] local_wdata,
  output reg  [31:0] local_rdata_q,
  output wire        local_irq_b,
  // Direct byte pins
  input  wire [7:0]  direct_byte_inputs,
  input  wire        direct_byte_load_strobe
);

  // Byte-enable mask placed at the mailbox's flag nibble
  function [15:0] box_mask;
    input [1:0] idx;
    input [3:0] be;
    begin
      box_mask = {12'h000, be} << {idx, 2'b00};
    end
  endfunction

  // Flag of the selected mailbox byte
  function sel_hit;
    input [15:0] v;
    input [3:0]  s;
    begin
      sel_hit = v[s];
    end
  endfunction

  // Byte-enabled merge of new data over old
  function [31:0] merge;
    input [31:0] o;
    input [31:0] n;
    input [3:0]  be;
    begin
      merge = {be[3] ? n[31:24] : o[31:24],
               be[2] ? n[23:16] : o[23:16],
               be[1] ? n[15:8]  : o[15:8],
               be[0] ? n[7:0]   : o[7:0]};
    end
  endfunction

  // Byte-enabled update of a configuration half; only writable bits move
  function [15:0] cfg_write;
    input [15:0] o;
    input [15:0] n;
    input [1:0]  be;
    reg   [15:0] m;
    begin
      m         = {{8{be[1]}}, {8{be[0]}}} & `PAM_CFG_MASK;
      cfg_write = (o & ~m) | (n & m);
    end
  endfunction

  // Mailbox storage: host-to-local and local-to-host words
  reg [31:0] h2l_q [0:3];
  reg [31:0] l2h_q [0:3];
  reg [15:0] h2l_full_q;
  reg [15:0] l2h_full_q;
  reg [15:0] hcfg_q;
  reg [15:0] lcfg_q;
  reg        hin_ind_q;
  reg        hout_ind_q;
  reg        lin_ind_q;
  reg        lout_ind_q;
  reg        stb_lock_q;
  reg [3:0]  lrd_addr_q;
  reg [3:0]  lrd_be_q;

  wire [15:0] h2l_full_d;
  wire [15:0] l2h_full_d;
  wire [15:0] h2l_set;
  wire [15:0] h2l_clr;
  wire [15:0] l2h_set;
  wire [15:0] l2h_lw_set;
  wire [15:0] l2h_clr;
  wire        hin_ind_d;
  wire        hout_ind_d;
  wire        lin_ind_d;
  wire        lout_ind_d;
  wire        stb_lock_d;

  // Access strobes, already qualified by the clock enable
  wire h_wr = ce & host_sel & host_wr;
  wire h_rd = ce & host_sel & ~host_wr;
  wire l_wr = ce & local_sel & ~local_wr_b;
  wire l_rd = ce & local_sel & ~local_rd_b;

  wire h_grp_h2l = host_addr[3:2] == `PAM_GRP_H2L;
  wire h_grp_l2h = host_addr[3:2] == `PAM_GRP_L2H;
  wire l_grp_h2l = local_addr[3:2] == `PAM_GRP_H2L;
  wire l_grp_l2h = local_addr[3:2] == `PAM_GRP_L2H;
  wire lrd_h2l   = lrd_addr_q[3:2] == `PAM_GRP_H2L;

  // Read completion is the rising edge of the local read strobe
  wire l_rd_done;
  wire stb_rise;

  pam_rise #(
    .IDLE (1'b1)
  ) u_rd_edge (
    .clock (clock),
    .rst_b (rst_b),
    .ce    (ce),
    .d     (local_rd_b),
    .rise  (l_rd_done)
  );

  // Strobe idles high; only a low-then-high pulse counts
  pam_rise #(
    .IDLE (1'b1)
  ) u_stb_edge (
    .clock (clock),
    .rst_b (rst_b),
    .ce    (ce),
    .d     (direct_byte_load_strobe),
    .rise  (stb_rise)
  );

  // Strobe path exists only without a byte-wide boot device
  wire stb_go = stb_rise & ~boot_bytewide;

  // Global flag reset from either control register; the bit rides in byte 3
  wire frst = (h_wr & host_addr == `PAM_A_CTRL & host_be[3]
               & host_wdata[`PAM_FLAG_RST_BIT])
            | (l_wr & local_addr == `PAM_A_CTRL & local_be[3]
               & local_wdata[`PAM_FLAG_RST_BIT]);

  // Flag set and clear vectors per byte enable
  assign h2l_set    = (h_wr & h_grp_h2l) ? box_mask(host_addr[1:0], host_be) : 16'h0000;
  assign l2h_lw_set = (l_wr & l_grp_l2h) ? box_mask(local_addr[1:0], local_be) : 16'h0000;
  assign l2h_set    = l2h_lw_set | (stb_go ? (16'h0001 << `PAM_DIRECT_FLAG) : 16'h0000);
  assign h2l_clr    = (l_rd_done & lrd_h2l) ? box_mask(lrd_addr_q[1:0], lrd_be_q) : 16'h0000;
  assign l2h_clr    = (h_rd & h_grp_l2h) ? box_mask(host_addr[1:0], host_be) : 16'h0000;

  // A new write beats a read-clear or global reset in the same cycle
  assign h2l_full_d = (h2l_full_q & ~(h2l_clr | {16{frst}})) | h2l_set;
  assign l2h_full_d = (l2h_full_q & ~(l2h_clr | {16{frst}})) | l2h_set;

  // Interrupt events
  wire hin_sel_stb = hcfg_q[`PAM_HI_IN_SEL] == `PAM_DIRECT_SEL;
  wire hin_ev_lw   = sel_hit(l2h_lw_set & ~l2h_full_q, hcfg_q[`PAM_HI_IN_SEL]);
  wire hin_ev_stb  = stb_go & hin_sel_stb & ~stb_lock_q;
  wire hin_ev      = hcfg_q[`PAM_HI_IN_EN] & (hin_ev_lw | hin_ev_stb);
  wire hout_ev     = hcfg_q[`PAM_HI_OUT_EN]
                   & sel_hit(h2l_clr & h2l_full_q, hcfg_q[`PAM_HI_OUT_SEL]);
  wire lin_ev      = lcfg_q[`PAM_LI_IN_EN]
                   & sel_hit(h2l_set & ~h2l_full_q, lcfg_q[`PAM_LI_IN_SEL]);
  wire lout_ev     = lcfg_q[`PAM_LI_OUT_EN]
                   & sel_hit(l2h_clr & l2h_full_q, lcfg_q[`PAM_LI_OUT_SEL]);

  // Write-one-to-clear of the pending indicators
  wire h_irq_wr  = h_wr & host_addr == `PAM_A_IRQ;
  wire l_irq_wr  = l_wr & local_addr == `PAM_A_IRQ;
  wire hclr_in   = h_irq_wr & host_be[2] & host_wdata[`PAM_HI_IN_IND];
  wire hclr_out  = h_irq_wr & host_be[2] & host_wdata[`PAM_HI_OUT_IND];
  wire lclr_in   = l_irq_wr & local_be[2] & local_wdata[`PAM_LI_IN_IND];
  wire lclr_out  = l_irq_wr & local_be[2] & local_wdata[`PAM_LI_OUT_IND];

  // Set wins over a clear arriving in the same cycle
  assign hin_ind_d  = hin_ev | (hin_ind_q & ~hclr_in);
  assign hout_ind_d = hout_ev | (hout_ind_q & ~hclr_out);
  assign lin_ind_d  = lin_ev | (lin_ind_q & ~lclr_in);
  assign lout_ind_d = lout_ev | (lout_ind_q & ~lclr_out);

  // Strobe lock holds until the host clears its incoming indicator
  assign stb_lock_d = (hin_ev_stb & hcfg_q[`PAM_HI_IN_EN]) | (stb_lock_q & ~hclr_in);

  // Flags, indicators and configuration
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      h2l_full_q <= 16'h0000;
      l2h_full_q <= 16'h0000;
      hcfg_q     <= `PAM_CFG_RST;
      lcfg_q     <= `PAM_CFG_RST;
      hin_ind_q  <= 1'b0;
      hout_ind_q <= 1'b0;
      lin_ind_q  <= 1'b0;
      lout_ind_q <= 1'b0;
      stb_lock_q <= 1'b0;
    end else if (ce) begin
      h2l_full_q <= h2l_full_d;
      l2h_full_q <= l2h_full_d;
      hin_ind_q  <= hin_ind_d;
      hout_ind_q <= hout_ind_d;
      lin_ind_q  <= lin_ind_d;
      lout_ind_q <= lout_ind_d;
      stb_lock_q <= stb_lock_d;
      if (h_irq_wr) begin
        hcfg_q <= cfg_write(hcfg_q, host_wdata[15:0], host_be[1:0]);
      end
      if (l_irq_wr) begin
        lcfg_q <= cfg_write(lcfg_q, local_wdata[15:0], local_be[1:0]);
      end
    end
  end

  // Mailbox data; writes overwrite whatever is unread
  integer i;
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (i = 0; i < 4; i = i + 1) begin
        h2l_q[i] <= 32'h0000_0000;
        l2h_q[i] <= 32'h0000_0000;
      end
    end else if (ce) begin
      if (h_wr & h_grp_h2l) begin
        h2l_q[host_addr[1:0]] <= merge(h2l_q[host_addr[1:0]], host_wdata, host_be);
      end
      if (l_wr & l_grp_l2h) begin
        l2h_q[local_addr[1:0]] <= merge(l2h_q[local_addr[1:0]], local_wdata, local_be);
      end
      // Strobe load beats a same-cycle local write to that byte
      if (stb_go) begin
        l2h_q[3][31:24] <= direct_byte_inputs;
      end
    end
  end

  // Latch the local read address while the read strobe is low
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lrd_addr_q <= 4'h0;
      lrd_be_q   <= 4'h0;
    end else if (l_rd) begin
      lrd_addr_q <= local_addr;
      lrd_be_q   <= local_be;
    end
  end

  // Host read mux; empty bytes still return their old data, except mailbox 4 byte 3 reads zero under a byte-wide boot
  reg [31:0] h_mux;
  always @* begin
    h_mux = 32'h0000_0000;
    if (h_grp_h2l) begin
      h_mux = h2l_q[host_addr[1:0]];
    end else if (h_grp_l2h) begin
      h_mux = l2h_q[host_addr[1:0]];
      if (boot_bytewide && host_addr[1:0] == 2'h3) begin
        h_mux[31:24] = 8'h00;
      end
    end else if (host_addr == `PAM_A_FLAGS) begin
      h_mux = {l2h_full_q, h2l_full_q};
    end else if (host_addr == `PAM_A_IRQ) begin
      h_mux = {14'h0000, hin_ind_q, hout_ind_q, hcfg_q};
    end
  end

  // Local read mux; same flag layout seen from the other side
  reg [31:0] l_mux;
  always @* begin
    l_mux = 32'h0000_0000;
    if (l_grp_h2l) begin
      l_mux = h2l_q[local_addr[1:0]];
    end else if (l_grp_l2h) begin
      l_mux = l2h_q[local_addr[1:0]];
    end else if (local_addr == `PAM_A_FLAGS) begin
      l_mux = {l2h_full_q, h2l_full_q};
    end else if (local_addr == `PAM_A_IRQ) begin
      l_mux = {14'h0000, lout_ind_q, lin_ind_q, lcfg_q};
    end
  end

  // Read data registers; they hold between reads, an interlock
  // against a write from the far side tearing a word mid-read
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      host_rdata_q  <= 32'h0000_0000;
      local_rdata_q <= 32'h0000_0000;
    end else begin
      if (h_rd) begin
        host_rdata_q <= h_mux;
      end
      if (l_rd) begin
        local_rdata_q <= l_mux;
      end
    end
  end

  // Single-phase target: a burst is cut after the current phase
  assign host_stop = host_sel & host_burst;

  // Host interrupt follows the indicators, changing on clock edges
  assign host_inta_b = ~(hin_ind_q | hout_ind_q);

  // Local interrupt drops in the clearing cycle, no edge needed
  assign local_irq_b = ~((lin_ind_q & ~lclr_in) | (lout_ind_q & ~lclr_out));

endmodule

`default_nettype wire

// *** pam_mailbox_assertions.sv ***
/*
 * Port checker for the mailbox block: interrupt timing, stop, direct byte.
 * Assumes binding onto pam_mailbox; all signals in the one clock domain.
 */
`timescale 1ns/100ps
`default_nettype none

module pam_mailbox_assertions (
  // Clock, reset, enable, strap
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic        boot_bytewide,
  // Host port
  input  wire logic        host_sel,
  input  wire logic        host_wr,
  input  wire logic        host_burst,
  input  wire logic [3:0]  host_addr,
  input  wire logic [3:0]  host_be,
  input  wire logic [31:0] host_wdata,
  input  wire logic [31:0] host_rdata_q,
  input  wire logic        host_stop,
  input  wire logic        host_inta_b,
  // Local port and direct strobe
  input  wire logic        local_sel,
  input  wire logic        local_wr_b,
  input  wire logic        local_rd_b,
  input  wire logic [3:0]  local_addr,
  input  wire logic [3:0]  local_be,
  input  wire logic [31:0] local_wdata,
  input  wire logic        local_irq_b,
  input  wire logic        direct_byte_load_strobe
);
  logic [12:8] hcfg_q;
  logic        hwr;
  logic        lwr;

  // Qualified writes on each port
  assign hwr = ce && host_sel && host_wr;
  assign lwr = ce && local_sel && !local_wr_b;

  // Shadow of the host incoming selection; the ports alone cannot tell it
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b)
      hcfg_q <= 5'h00;
    else if (hwr && host_addr == 4'h9 && host_be[1])
      hcfg_q <= host_wdata[12:8];
  end

  default clocking dc @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_stop_on_burst: assert property (
    host_stop == (host_sel && host_burst))
    else $error("stop differs from burst data phase");
  a_host_in_fire: assert property (
    lwr && hcfg_q[12] && local_addr == {2'h1, hcfg_q[11:10]} && local_be[hcfg_q[9:8]]
    |=> !host_inta_b)
    else $error("host interrupt missed after local write");
  a_strobe_fire: assert property (
    ce && $past(ce) && !boot_bytewide && hcfg_q[12] && hcfg_q[11:8] == 4'hf
    && direct_byte_load_strobe && !$past(direct_byte_load_strobe) |=> !host_inta_b)
    else $error("host interrupt missed after strobe");
  a_host_drop: assert property (
    hwr && host_addr == 4'h9 && host_be[2] && host_wdata[17:16] == 2'h3 && !local_sel
    && local_rd_b && $past(local_rd_b) && direct_byte_load_strobe
    && $past(direct_byte_load_strobe) |=> host_inta_b)
    else $error("host interrupt kept after clear");
  a_local_clear_now: assert property (
    lwr && local_addr == 4'h9 && local_be[2] && local_wdata[17:16] == 2'h3 |-> local_irq_b)
    else $error("local interrupt not dropped at once");
  a_bytewide_zero: assert property (
    ce && host_sel && !host_wr && host_addr == 4'h7 && boot_bytewide
    |=> host_rdata_q[31:24] == 8'h00)
    else $error("direct byte not zero with bytewide boot");
  a_inta_cause: assert property (
    $fell(host_inta_b) |-> $past(local_sel) || !$past(local_rd_b, 2)
    || !$past(direct_byte_load_strobe, 2))
    else $error("host interrupt without a cause");
  a_irq_cause: assert property (
    $fell(local_irq_b) |-> $past(host_sel))
    else $error("local interrupt without host access");
endmodule

bind pam_mailbox pam_mailbox_assertions chk (.*);

`default_nettype wire

// *** pam_strobe_drv.sv ***
/*
 * Stand-in for the external hardware on the direct byte pins.
 * Assumes the bench clock; data turns over once the load edge passed.
 */
`timescale 1ns/100ps
`default_nettype none

module pam_strobe_drv (
  // Clock
  input  wire logic       clock,
  // Direct byte pins
  output logic            strobe,
  output logic [7:0]      dat
);
  // Strobe idles high
  initial begin
    strobe = 1'h1;
    dat = 8'h00;
  end

  // Low for one cycle, then high; old data is not left standing
  task pulse(input logic [7:0] v);
    @(posedge clock);
    strobe <= 1'h0;
    dat <= v;
    @(posedge clock);
    strobe <= 1'h1;
    @(posedge clock);
    dat <= ~v;
    #1;
  endtask
endmodule

`default_nettype wire

// *** pam_mailbox_test.sv ***
/*
 * Self-checking bench for the mailbox block through both access ports.
 * Assumes pam_strobe_drv for the direct byte pins and the bound checker.
 */
`timescale 1ns/100ps
`default_nettype none

module pam_mailbox_test;
  logic        clock;
  logic        rst_b = 1'h0, ce = 1'h1, boot_bytewide = 1'h0, host_burst = 1'h0;
  logic        host_sel = 1'h0, host_wr = 1'h0, local_sel = 1'h0;
  logic        local_wr_b = 1'h1, local_rd_b = 1'h1;
  logic [3:0]  host_addr = 4'h0, host_be = 4'h0, local_addr = 4'h0, local_be = 4'h0;
  logic [31:0] host_wdata = 32'h0, local_wdata = 32'h0;
  wire  [31:0] host_rdata_q, local_rdata_q;
  wire         host_stop, host_inta_b, local_irq_b, strobe;
  wire  [7:0]  dbyte;
  int          fail_count = 0, checked = 0;

  pam_mailbox uut (
    .clock(clock), .rst_b(rst_b), .ce(ce), .boot_bytewide(boot_bytewide),
    .host_sel(host_sel), .host_wr(host_wr), .host_burst(host_burst),
    .host_addr(host_addr), .host_be(host_be), .host_wdata(host_wdata),
    .host_rdata_q(host_rdata_q), .host_stop(host_stop), .host_inta_b(host_inta_b),
    .local_sel(local_sel), .local_wr_b(local_wr_b), .local_rd_b(local_rd_b),
    .local_addr(local_addr), .local_be(local_be), .local_wdata(local_wdata),
    .local_rdata_q(local_rdata_q), .local_irq_b(local_irq_b),
    .direct_byte_inputs(dbyte), .direct_byte_load_strobe(strobe));
  pam_strobe_drv ext (.clock(clock), .strobe(strobe), .dat(dbyte));

  // 200 MHz clock
  initial begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end

  task give_verdict;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  // One host data phase, taken at the second edge
  task hx(input logic w, input logic [3:0] a, b, input logic [31:0] d);
    @(posedge clock);
    host_sel <= 1'h1;
    host_wr <= w;
    host_addr <= a;
    host_be <= b;
    host_wdata <= d;
    @(posedge clock);
    host_sel <= 1'h0;
    #1;
  endtask

  task hr(input logic [3:0] a, b, input logic [31:0] e, input string n);
    hx(1'h0, a, b, 32'h0);
    chk(n, e, host_rdata_q);
  endtask

  task lw(input logic [3:0] a, b, input logic [31:0] d);
    @(posedge clock);
    local_sel <= 1'h1;
    local_wr_b <= 1'h0;
    local_addr <= a;
    local_be <= b;
    local_wdata <= d;
    @(posedge clock);
    local_sel <= 1'h0;
    local_wr_b <= 1'h1;
    #1;
  endtask

  // Select held through the read strobe rise, which ends the read
  task lr(input logic [3:0] a, b, input logic [31:0] e, input string n);
    @(posedge clock);
    local_sel <= 1'h1;
    local_rd_b <= 1'h0;
    local_addr <= a;
    local_be <= b;
    @(posedge clock);
    local_rd_b <= 1'h1;
    @(posedge clock);
    local_sel <= 1'h0;
    #1;
    chk(n, e, local_rdata_q);
  endtask

  // Cuts a hang short
  initial begin
    #100000;
    fail_count++;
    give_verdict;
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge clock);
    rst_b <= 1'h1;
    #1;
    chk("inta", 32'h1, 32'(host_inta_b));
    chk("irq", 32'h1, 32'(local_irq_b));
    hr(4'h8, 4'hf, 32'h0, "host flags");
    lr(4'h9, 4'hf, 32'h0, "local irq reg");
    hr(4'hb, 4'hf, 32'h0, "unmapped");
    $display("test reset done");
    lw(4'h9, 4'h1, 32'h15);
    hx(1'h1, 4'h9, 4'h1, 32'h14);
    hx(1'h1, 4'h1, 4'h3, 32'hbbaa);
    chk("irq", 32'h0, 32'(local_irq_b));
    hr(4'h8, 4'hf, 32'h30, "host flags");
    lr(4'h8, 4'hf, 32'h30, "local flags");
    hx(1'h1, 4'h1, 4'h1, 32'hcc);
    fork
      lw(4'h9, 4'h4, 32'h30000);
      begin
        @(posedge clock);
        #1;
        chk("irq clear", 32'h1, 32'(local_irq_b));
      end
    join
    lr(4'h1, 4'h3, 32'hbbcc, "local inbox 2");
    chk("inta", 32'h0, 32'(host_inta_b));
    hr(4'h8, 4'hf, 32'h0, "host flags");
    hx(1'h1, 4'h9, 4'h4, 32'h30000);
    chk("inta", 32'h1, 32'(host_inta_b));
    lr(4'h1, 4'h3, 32'hbbcc, "empty reread");
    chk("inta", 32'h1, 32'(host_inta_b));
    hr(4'h9, 4'hf, 32'h14, "host irq reg");
    $display("test host to local done");
    hx(1'h1, 4'h9, 4'h2, 32'h1000);
    lw(4'h4, 4'h1, 32'h77);
    chk("inta", 32'h0, 32'(host_inta_b));
    hr(4'h8, 4'hf, 32'h10000, "host flags");
    hr(4'h4, 4'h1, 32'h77, "host inbox 1");
    hx(1'h1, 4'h9, 4'h4, 32'h30000);
    lw(4'h5, 4'hf, 32'h01020304);
    hx(1'h1, 4'h8, 4'hf, 32'hffffffff);
    hr(4'h8, 4'hf, 32'hf00000, "read-only flags");
    lw(4'ha, 4'hf, 32'h0);
    hr(4'h8, 4'hf, 32'hf00000, "flags kept");
    lw(4'ha, 4'h8, 32'h08000000);
    hr(4'h8, 4'hf, 32'h0, "flags reset");
    lw(4'h9, 4'h2, 32'h1400);
    lw(4'h5, 4'h1, 32'h99);
    lw(4'h5, 4'h4, 32'haa0000);
    @(posedge clock);
    ce <= 1'h0;
    lw(4'h5, 4'h1, 32'h55);
    ce <= 1'h1;
    hr(4'h5, 4'h5, 32'h01aa0399, "local outbox 2");
    chk("irq", 32'h0, 32'(local_irq_b));
    lw(4'h9, 4'h4, 32'h20000);
    chk("irq clear", 32'h1, 32'(local_irq_b));
    $display("test local to host done");
    hx(1'h1, 4'h9, 4'h2, 32'h1f00);
    ext.pulse(8'ha5);
    chk("inta", 32'h0, 32'(host_inta_b));
    hr(4'h8, 4'hf, 32'h80000000, "host flags");
    hr(4'h7, 4'h8, 32'ha5000000, "direct byte");
    hx(1'h1, 4'h9, 4'h4, 32'h30000);
    @(posedge clock);
    boot_bytewide <= 1'h1;
    host_burst <= 1'h1;
    ext.pulse(8'h3c);
    chk("inta", 32'h1, 32'(host_inta_b));
    fork
      hr(4'h7, 4'h8, 32'h0, "bytewide byte");
      begin
        @(posedge clock);
        #1;
        chk("stop", 32'h1, 32'(host_stop));
      end
    join
    chk("stop idle", 32'h0, 32'(host_stop));
    $display("test direct byte done");
    give_verdict;
  end
endmodule

`default_nettype wire
